// [design/lbc_pkg.sv]
// Constants and types of the LED buck control block
// Functional notes
// - Count overcurrent periods up to threshold plus one
// - Clear count on low current, disable, dimming
// - Hold buck off until flag is read
// - Flag read re-enables the buck automatically
// - Buck follows dimming input after phase delay
// - Same delay on both edges, duty preserved for pulses longer than the delay
// - Sequencer steps mux over all sources, stores
// - Reads never disturb sequencer, return latest
// - 8 us slots, 16/32 us refresh rates
// - Nonzero duration forces LED conversions periodically
// - Delayed falling edge requests LED conversion
// - Dimming high updates on-voltage and plain voltage
// - One LED channel, full sequence between
// - Priority starts channel 1, toggles per service
// - Results carry odd parity at bit 8
// - Trim scales peak by 1+0.4(t-63)/63
// - Temperature coefficients are signed 4-bit values
// - Overcurrent sets latched flag at 0x13
// - Dimming inputs debounced 200 ns
package lbc_pkg;

    // Timing
    localparam int  CLK_PERIOD_NS   = 8;
    localparam int  DEBOUNCE_NS     = 200;
    localparam int  DEBOUNCE_CYC    = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam real PHASE_DELAY_US  = 5.5;
    localparam int  PHASE_DELAY_CYC = int'(PHASE_DELAY_US * 1000.0 / CLK_PERIOD_NS);
    localparam int  CONV_SLOT_US    = 8;
    localparam int  CONV_SLOT_CYC   = CONV_SLOT_US * 1000 / CLK_PERIOD_NS;
    localparam int  SEQ_PERIOD_US   = 32;
    localparam int  SLOTS_PER_SEQ   = SEQ_PERIOD_US / CONV_SLOT_US;

    // Widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int ADC_W  = 8;
    localparam int RES_W  = 9;
    localparam int DEB_W  = 5;
    localparam int DLY_W  = 10;
    localparam int TMR_W  = 10;
    localparam int CNT_W  = 3;
    localparam int DUR_W  = 9;
    localparam int TRIM_W = 7;
    localparam int TC_W   = 4;
    localparam int PK_W   = 9;

    localparam logic [DEB_W-1:0] DEB_LOAD  = DEB_W'(DEBOUNCE_CYC);
    localparam logic [DLY_W-1:0] DLY_LOAD  = DLY_W'(PHASE_DELAY_CYC);
    localparam logic [TMR_W-1:0] SLOT_LAST = TMR_W'(CONV_SLOT_CYC - 1);
    localparam logic [1:0]       SLOT_END  = 2'(SLOTS_PER_SEQ - 1);
    localparam logic [2:0]       SLOTS_N   = 3'(SLOTS_PER_SEQ);

    // Register offsets
    localparam logic [ADDR_W-1:0] A_CTRL    = 8'h00;
    localparam logic [ADDR_W-1:0] A_FORCED  = 8'h01;
    localparam logic [ADDR_W-1:0] A_TRIM1   = 8'h02;
    localparam logic [ADDR_W-1:0] A_TRIM2   = 8'h03;
    localparam logic [ADDR_W-1:0] A_CODE1   = 8'h04;
    localparam logic [ADDR_W-1:0] A_CODE2   = 8'h05;
    localparam logic [ADDR_W-1:0] A_TC0     = 8'h06;
    localparam logic [ADDR_W-1:0] A_STATUS  = 8'h13;
    localparam logic [ADDR_W-1:0] A_RES_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] A_RES_LAST = 8'h26;

    // Control register fields
    localparam int CTRL_EN1   = 0;
    localparam int CTRL_EN2   = 1;
    localparam int CTRL_THR1  = 2;
    localparam int CTRL_THR2  = 4;
    localparam int CTRL_SCHEME = 6;
    localparam int CTRL_W     = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

    // Status register fields
    localparam int ST_OC1   = 0;
    localparam int ST_BUCK1 = 2;
    localparam int ST_DIM1  = 4;
    localparam int ST_W     = 6;

    // Reset values
    localparam logic [TRIM_W-1:0] TRIM_RST = 7'h3f;
    localparam logic [ADC_W-1:0]  CODE_RST = 8'h00;
    localparam logic [DUR_W-1:0]  DUR_RST  = 9'h000;
    localparam logic [RES_W-1:0]  RES_RST  = 9'h100;

    // Trim scaling: 1 + NUM/DEN * (t - MID) / MID
    localparam int TRIM_MID = 63;
    localparam int TRIM_NUM = 2;
    localparam int TRIM_DEN = 5;
    localparam int TRIM_OFS = TRIM_DEN * TRIM_MID - TRIM_NUM * TRIM_MID;
    localparam int TRIM_DIV = TRIM_DEN * TRIM_MID;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } lbc_bus_req_t;

    typedef enum logic [2:0] {
        MUX_HIGH_SUPPLY  = 3'h0,
        MUX_LOGIC_SUPPLY = 3'h1,
        MUX_DIE_TEMP     = 3'h2,
        MUX_LED1         = 3'h3,
        MUX_LED2         = 3'h4
    } lbc_mux_t;

    typedef enum logic [2:0] {
        RES_HIGH_SUPPLY  = 3'h0,
        RES_LOGIC_SUPPLY = 3'h1,
        RES_DIE_TEMP     = 3'h2,
        RES_LED1_ON      = 3'h3,
        RES_LED1         = 3'h4,
        RES_LED2_ON      = 3'h5,
        RES_LED2         = 3'h6
    } lbc_res_t;

    typedef enum logic [1:0] {
        SEQ_LAUNCH = 2'b00,
        SEQ_CONV   = 2'b01,
        SEQ_NEXT   = 2'b11
    } lbc_seq_t;

endpackage

// [design/lbc_result_mem.sv]
// Result store with registered read port
`timescale 1ns/1ps
module lbc_result_mem
    import lbc_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // Write side
    input  wire logic              wr_en,
    input  wire logic [2:0]        wr_addr,
    input  wire logic [RES_W-1:0]  wr_data,
    // Read side
    input  wire logic              rd_en,
    input  wire logic              rd_mem,
    input  wire logic [2:0]        rd_addr,
    input  wire logic [DATA_W-1:0] rd_reg_val,
    output logic      [DATA_W-1:0] rd_data_q
);

    logic [RES_W-1:0] mem_q [8];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 8; i++) begin
                mem_q[i] <= RES_RST;
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    // Same-cycle write returns old word
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            rd_data_q <= rd_mem ? {{(DATA_W-RES_W){1'b0}}, mem_q[rd_addr]} : rd_reg_val;
        end else begin
            rd_data_q <= '0;
        end
    end

endmodule // lbc_result_mem

// [design/lbc_led_buck_ctrl.sv]
// Overcurrent, dimming and converter sequencing for two LED buck channels
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module lbc_led_buck_ctrl
    import lbc_pkg::*;
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // Register port
    input  wire lbc_bus_req_t      bus_req,
    output logic      [DATA_W-1:0] rdata,
    // Channel pins and analog comparators
    input  wire logic [1:0]        dim_control_input,
    input  wire logic [1:0]        overcurrent_limit_level,
    input  wire logic [1:0]        buck_period,
    // Buck drive and flags
    output logic      [1:0]        buck_on_q,
    output logic      [1:0]        overcurrent_flag_q,
    output logic      [PK_W-1:0]   peak_threshold_code1_q,
    output logic      [PK_W-1:0]   peak_threshold_code2_q,
    // Converter macro
    output logic                   adc_start_q,
    output lbc_mux_t               adc_mux_sel_q,
    input  wire logic              adc_done,
    input  wire logic [ADC_W-1:0]  adc_data
);

    function automatic logic [RES_W-1:0] with_parity(input logic [ADC_W-1:0] d);
        with_parity = {~^d, d};
    endfunction

    function automatic logic [PK_W-1:0] trim_scale(input logic [ADC_W-1:0] code,
                                                   input logic [TRIM_W-1:0] trim);
        logic [16:0] prod;
        prod = 17'(code) * (17'(TRIM_OFS) + 17'(TRIM_NUM) * 17'(trim));
        trim_scale = PK_W'(prod / 17'(TRIM_DIV));
    endfunction

    function automatic lbc_mux_t main_mux(input logic [1:0] idx);
        main_mux = (idx == 2'd1) ? MUX_LOGIC_SUPPLY :
                   (idx == SLOT_END) ? MUX_DIE_TEMP : MUX_HIGH_SUPPLY;
    endfunction

    // Software registers
    logic [CTRL_W-1:0] ctrl_q;
    logic [DUR_W-1:0]  forced_interrupt_sequences_q;
    logic [TRIM_W-1:0] peak_current_trim_q [2];
    logic [ADC_W-1:0]  peak_code_q [2];
    logic [TC_W-1:0]   range_temp_coefficient_q [4];

    // Pin synchronisers
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic [1:0] per_prev_q;

    // Dimming path
    logic [DEB_W-1:0] deb_cnt_q [2];
    logic [1:0]       deb_q;
    logic [DLY_W-1:0] dly_cnt_q [2];
    logic [1:0]       dly_tgt_q;
    logic [1:0]       dly_out_q;
    logic [1:0]       dly_prev_q;

    // Overcurrent
    logic [CNT_W-1:0] oc_cnt_q [2];

    // Sequencer
    lbc_seq_t         state_q;
    logic [TMR_W-1:0] tmr_q;
    logic [1:0]       idx_q;
    logic             cur_led_q;
    logic             cur_ch_q;
    logic             pend_on_q;
    logic [2:0]       since_q;
    logic [1:0]       req_q;
    logic             prio_q;
    logic [DUR_W-1:0] fcnt_q;

    logic [1:0] ch_en;
    logic [1:0] thr [2];
    logic [1:0] oc_s;
    logic [1:0] per_edge;
    logic [1:0] dim_rise;
    logic [1:0] dim_fall;
    logic [1:0] oc_set;
    logic       status_rd;
    logic       wr_hit;
    logic       main_done;
    logic       seq_end;
    logic       allow;
    logic       take;
    logic       pick;
    logic       force_now;
    logic [1:0] req_set;
    logic [1:0] req_clr;

    logic             mem_wr;
    logic [2:0]       mem_waddr;
    logic [RES_W-1:0] mem_wdata;
    logic             rd_mem;
    logic [DATA_W-1:0] reg_val;
    logic [ADC_W-1:0]  adc_data_hold_q;

    assign ch_en     = {ctrl_q[CTRL_EN2], ctrl_q[CTRL_EN1]};
    assign thr[0]    = ctrl_q[CTRL_THR1 +: 2];
    assign thr[1]    = ctrl_q[CTRL_THR2 +: 2];
    assign oc_s      = sync2_q[3:2];
    assign per_edge  = sync2_q[5:4] & ~per_prev_q;
    assign dim_rise  = dly_out_q & ~dly_prev_q;
    assign dim_fall  = ~dly_out_q & dly_prev_q;
    assign status_rd = bus_req.re && (bus_req.addr == A_STATUS);
    assign wr_hit    = bus_req.we;

    // Register writes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q                       <= CTRL_RST;
            forced_interrupt_sequences_q <= DUR_RST;
            for (int i = 0; i < 2; i++) begin
                peak_current_trim_q[i] <= TRIM_RST;
                peak_code_q[i]         <= CODE_RST;
            end
            for (int i = 0; i < 4; i++) begin
                range_temp_coefficient_q[i] <= '0;
            end
        end else if (wr_hit) begin
            unique case (bus_req.addr)
                A_CTRL:   ctrl_q <= bus_req.wdata[CTRL_W-1:0];
                A_FORCED: forced_interrupt_sequences_q <= bus_req.wdata[DUR_W-1:0];
                A_TRIM1:  peak_current_trim_q[0] <= bus_req.wdata[TRIM_W-1:0];
                A_TRIM2:  peak_current_trim_q[1] <= bus_req.wdata[TRIM_W-1:0];
                A_CODE1:  peak_code_q[0] <= bus_req.wdata[ADC_W-1:0];
                A_CODE2:  peak_code_q[1] <= bus_req.wdata[ADC_W-1:0];
                A_TC0, A_TC0 + 8'h01, A_TC0 + 8'h02, A_TC0 + 8'h03: begin
                    range_temp_coefficient_q[2'(bus_req.addr - A_TC0)] <=
                        bus_req.wdata[TC_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Scaled peak thresholds
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            peak_threshold_code1_q <= '0;
            peak_threshold_code2_q <= '0;
        end else begin
            peak_threshold_code1_q <= trim_scale(peak_code_q[0], peak_current_trim_q[0]);
            peak_threshold_code2_q <= trim_scale(peak_code_q[1], peak_current_trim_q[1]);
        end
    end

    // Two-stage synchronisers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            per_prev_q <= '0;
        end else begin
            sync1_q    <= {buck_period, overcurrent_limit_level, dim_control_input};
            sync2_q    <= sync1_q;
            per_prev_q <= sync2_q[5:4];
        end
    end

    // Debounce: level must hold the full window
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            deb_q <= '0;
            for (int i = 0; i < 2; i++) begin
                deb_cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (sync2_q[i] == deb_q[i]) begin
                    deb_cnt_q[i] <= '0;
                end else if (deb_cnt_q[i] == DEB_LOAD - 5'h01) begin
                    deb_q[i]     <= sync2_q[i];
                    deb_cnt_q[i] <= '0;
                end else begin
                    deb_cnt_q[i] <= deb_cnt_q[i] + 5'h01;
                end
            end
        end
    end

    // Phase delay; a pulse shorter than the delay is stretched, not lost
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dly_tgt_q  <= '0;
            dly_out_q  <= '0;
            dly_prev_q <= '0;
            for (int i = 0; i < 2; i++) begin
                dly_cnt_q[i] <= '0;
            end
        end else begin
            dly_prev_q <= dly_out_q;
            for (int i = 0; i < 2; i++) begin
                if (dly_cnt_q[i] != '0) begin
                    if (dly_cnt_q[i] == 10'h001) begin
                        dly_out_q[i] <= dly_tgt_q[i];
                    end
                    dly_cnt_q[i] <= dly_cnt_q[i] - 10'h001;
                end else if (deb_q[i] != dly_out_q[i]) begin
                    dly_tgt_q[i] <= deb_q[i];
                    dly_cnt_q[i] <= DLY_LOAD;
                end
            end
        end
    end

    // Overcurrent period counter
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            oc_set[i] = ch_en[i] && oc_s[i] && per_edge[i] && !dim_rise[i] &&
                        !overcurrent_flag_q[i] && (oc_cnt_q[i] == {1'b0, thr[i]});
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < 2; i++) begin
                oc_cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!ch_en[i] || !oc_s[i] || dim_rise[i] || (status_rd && !oc_set[i])) begin
                    oc_cnt_q[i] <= '0;
                end else if (per_edge[i] && !overcurrent_flag_q[i]) begin
                    oc_cnt_q[i] <= oc_cnt_q[i] + 3'h1;
                end
            end
        end
    end

    // Latched flag; set wins over read clear
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            overcurrent_flag_q <= '0;
        end else begin
            overcurrent_flag_q <= oc_set | (overcurrent_flag_q & ~{2{status_rd}});
        end
    end

    // Buck drive
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            buck_on_q <= '0;
        end else begin
            buck_on_q <= ch_en & dly_out_q & ~overcurrent_flag_q & ~oc_set;
        end
    end

    // Slot boundary decisions
    assign main_done = !cur_led_q;
    assign seq_end   = main_done && (idx_q == SLOT_END);
    assign allow     = (since_q + 3'(main_done)) >= SLOTS_N;
    assign take      = (state_q == SEQ_NEXT) && allow && (req_q != 2'b00);
    assign pick      = (req_q == 2'b11) ? prio_q : req_q[1];
    assign force_now = (state_q == SEQ_NEXT) && seq_end &&
                       (forced_interrupt_sequences_q != '0) &&
                       (fcnt_q + 9'h001 >= forced_interrupt_sequences_q);

    always_comb begin
        req_set = dim_fall;
        if (force_now) begin
            req_set[prio_q] = 1'b1;
        end
        req_clr = '0;
        if (take) begin
            req_clr[pick] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            req_q <= '0;
        end else begin
            req_q <= req_set | (req_q & ~req_clr);
        end
    end

    // Priority toggles per service
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prio_q <= 1'b0;
        end else if (take) begin
            prio_q <= ~prio_q;
        end
    end

    // Sequences without LED slot
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fcnt_q <= '0;
        end else if (take || force_now || forced_interrupt_sequences_q == '0) begin
            fcnt_q <= '0;
        end else if (state_q == SEQ_NEXT && seq_end) begin
            fcnt_q <= fcnt_q + 9'h001;
        end
    end

    // Main slots since last LED slot
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            since_q <= SLOTS_N;
        end else if (take) begin
            since_q <= '0;
        end else if (state_q == SEQ_NEXT && main_done && since_q < SLOTS_N) begin
            since_q <= since_q + 3'h1;
        end
    end

    // Slot machine; each slot lasts full conversion time
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q       <= SEQ_LAUNCH;
            tmr_q         <= '0;
            idx_q         <= '0;
            cur_led_q     <= 1'b0;
            cur_ch_q      <= 1'b0;
            adc_start_q   <= 1'b0;
            adc_mux_sel_q <= MUX_HIGH_SUPPLY;
        end else begin
            unique case (state_q)
                SEQ_LAUNCH: begin
                    adc_start_q   <= 1'b1;
                    adc_mux_sel_q <= cur_led_q ? (cur_ch_q ? MUX_LED2 : MUX_LED1)
                                               : main_mux(idx_q);
                    tmr_q         <= SLOT_LAST;
                    state_q       <= SEQ_CONV;
                end
                SEQ_CONV: begin
                    adc_start_q <= 1'b0;
                    tmr_q       <= tmr_q - 10'h001;
                    if (tmr_q == '0) begin
                        state_q <= SEQ_NEXT;
                    end
                end
                SEQ_NEXT: begin
                    if (main_done) begin
                        idx_q <= idx_q + 2'h1;
                    end
                    cur_led_q <= take;
                    if (take) begin
                        cur_ch_q <= pick;
                    end
                    state_q <= SEQ_LAUNCH;
                end
                default: begin
                    state_q <= SEQ_LAUNCH;
                end
            endcase
        end
    end

    // On-voltage write waits for slot end to share the port
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pend_on_q <= 1'b0;
        end else if (state_q == SEQ_CONV && adc_done && cur_led_q) begin
            pend_on_q <= deb_q[cur_ch_q];
        end else if (state_q == SEQ_NEXT) begin
            pend_on_q <= 1'b0;
        end
    end

    always_comb begin
        mem_wr    = 1'b0;
        mem_waddr = RES_HIGH_SUPPLY;
        mem_wdata = with_parity(adc_data);
        if (state_q == SEQ_CONV && adc_done) begin
            mem_wr = 1'b1;
            if (cur_led_q) begin
                mem_waddr = cur_ch_q ? RES_LED2 : RES_LED1;
            end else if (idx_q == 2'd1) begin
                mem_waddr = RES_LOGIC_SUPPLY;
            end else if (idx_q == SLOT_END) begin
                mem_waddr = RES_DIE_TEMP;
            end
        end else if (state_q == SEQ_NEXT && pend_on_q) begin
            mem_wr    = 1'b1;
            mem_waddr = cur_ch_q ? RES_LED2_ON : RES_LED1_ON;
            mem_wdata = with_parity(adc_data_hold_q);
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            adc_data_hold_q <= '0;
        end else if (state_q == SEQ_CONV && adc_done) begin
            adc_data_hold_q <= adc_data;
        end
    end

    // Register read values
    assign rd_mem = (bus_req.addr >= A_RES_BASE) && (bus_req.addr <= A_RES_LAST);

    always_comb begin
        reg_val = '0;
        unique case (bus_req.addr)
            A_CTRL:   reg_val = DATA_W'(ctrl_q);
            A_FORCED: reg_val = DATA_W'(forced_interrupt_sequences_q);
            A_TRIM1:  reg_val = DATA_W'(peak_current_trim_q[0]);
            A_TRIM2:  reg_val = DATA_W'(peak_current_trim_q[1]);
            A_CODE1:  reg_val = DATA_W'(peak_code_q[0]);
            A_CODE2:  reg_val = DATA_W'(peak_code_q[1]);
            A_TC0, A_TC0 + 8'h01, A_TC0 + 8'h02, A_TC0 + 8'h03: begin
                reg_val = DATA_W'(range_temp_coefficient_q[2'(bus_req.addr - A_TC0)]);
            end
            A_STATUS: begin
                reg_val[ST_OC1 +: 2]   = overcurrent_flag_q;
                reg_val[ST_BUCK1 +: 2] = buck_on_q;
                reg_val[ST_DIM1 +: 2]  = deb_q;
            end
            default: begin
                reg_val = '0;
            end
        endcase
    end

    lbc_result_mem u_mem (
        .sys_clk    (sys_clk),
        .rstn       (rstn),
        .wr_en      (mem_wr),
        .wr_addr    (mem_waddr),
        .wr_data    (mem_wdata),
        .rd_en      (bus_req.re),
        .rd_mem     (rd_mem),
        .rd_addr    (3'(bus_req.addr - A_RES_BASE)),
        .rd_reg_val (reg_val),
        .rd_data_q  (rdata)
    );

endmodule // lbc_led_buck_ctrl

// [sim/lbc_ctrl_properties.sv]
// Port assertions, LED buck control
`timescale 1ns/1ps
module lbc_ctrl_properties
    import lbc_pkg::*;
(
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              rstn,
    // Watched ports
    input wire lbc_bus_req_t      bus_req,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0]        buck_on_q,
    input wire logic [1:0]        overcurrent_flag_q,
    input wire logic              adc_start_q,
    input wire lbc_mux_t          adc_mux_sel_q
);
    logic [10:0] gap_q;
    wire         st_rd = bus_req.re && bus_req.addr == A_STATUS;
    // Saturates so a stall trips
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) gap_q <= '0;
        else if (adc_start_q) gap_q <= 11'd1;
        else if (gap_q != '0 && gap_q != 11'h7ff) gap_q <= gap_q + 11'd1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    off_when_flagged_a: assert property ((overcurrent_flag_q & buck_on_q) == 2'b00)
        else $error("buck on while flagged");
    flag_kept_a: assert property (
        |(~overcurrent_flag_q & $past(overcurrent_flag_q)) |-> $past(st_rd))
        else $error("flag cleared unread");
    status_read_a: assert property (st_rd |=> rdata[15:6] == '0 &&
        rdata[3:0] == {$past(buck_on_q), $past(overcurrent_flag_q)})
        else $error("bad status data");
    read_idle_a: assert property (!bus_req.re |=> rdata == '0)
        else $error("stray read data");
    start_pulse_a: assert property (adc_start_q |=> !adc_start_q)
        else $error("long start");
    slot_len_a: assert property (adc_start_q && gap_q != '0 |-> gap_q == 11'd1002)
        else $error("slot length wrong");
    slot_due_a: assert property (gap_q <= 11'd1002)
        else $error("slot overdue");
    mux_hold_a: assert property (adc_start_q |=> $stable(adc_mux_sel_q) [*8])
        else $error("mux moved");
    mux_legal_a: assert property (adc_mux_sel_q <= MUX_LED2)
        else $error("mux out of range");
endmodule // lbc_ctrl_properties

bind lbc_led_buck_ctrl lbc_ctrl_properties i_lbc_ctrl_properties (.sys_clk(sys_clk),
    .rstn(rstn), .bus_req(bus_req), .rdata(rdata), .buck_on_q(buck_on_q),
    .overcurrent_flag_q(overcurrent_flag_q), .adc_start_q(adc_start_q),
    .adc_mux_sel_q(adc_mux_sel_q));

// [sim/lbc_adc_model.sv]
// Converter model answering each start after lat cycles
`timescale 1ns/1ps
module lbc_adc_model
    import lbc_pkg::*;
(
    // Clock and reset
    input wire logic             sys_clk,
    input wire logic             rstn,
    // Handshake
    input wire logic             adc_start,
    input wire lbc_mux_t         mux,
    input wire logic [9:0]       lat,
    output logic                 done_q,
    output logic     [ADC_W-1:0] data_q
);
    logic [9:0] cnt_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q  <= '0;
            done_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            cnt_q  <= adc_start ? 10'd1 : cnt_q + 10'(cnt_q != '0);
            done_q <= cnt_q == lat;
            // Toggles off done so stale data never match
            data_q <= (cnt_q == lat) ? 8'h31 * (8'(mux) + 8'h01) : ~data_q;
        end
    end
endmodule // lbc_adc_model

// [sim/tb.sv]
// Self-checking bench for the LED buck control block
`timescale 1ns/1ps
module tb;
    import lbc_pkg::*;
    logic              sys_clk = 1'b0, rstn, start, done;
    logic [1:0]        dim = '0, lim = '0, per = '0, on, flag;
    logic [DATA_W-1:0] rdata, v;
    logic [PK_W-1:0]   pk1;
    logic [ADC_W-1:0]  ad;
    logic [9:0]        lat;
    lbc_mux_t          mux;
    lbc_bus_req_t      req = '0;
    int bad_count = 0, tests_run = 0, seed = 32'hecc119ad, lr, lf, tr, cd;
    lbc_led_buck_ctrl i_lbc_led_buck_ctrl (.sys_clk(sys_clk), .rstn(rstn), .bus_req(req),
        .rdata(rdata), .dim_control_input(dim), .overcurrent_limit_level(lim),
        .buck_period(per), .buck_on_q(on), .overcurrent_flag_q(flag),
        .peak_threshold_code1_q(pk1), .peak_threshold_code2_q(), .adc_start_q(start),
        .adc_mux_sel_q(mux), .adc_done(done), .adc_data(ad));
    lbc_adc_model i_lbc_adc_model (.sys_clk(sys_clk), .rstn(rstn), .adc_start(start),
        .mux(mux), .lat(lat), .done_q(done), .data_q(ad));
    initial forever #4 sys_clk = ~sys_clk;
    function automatic logic [15:0] res(logic [7:0] d);
        return {7'h00, ~^d, d};
    endfunction
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge sys_clk) req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk) req.we <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge sys_clk) req <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge sys_clk) req.re <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wt(logic b, output int n);
        n = 0;
        while (on[0] !== b && n < 2000) begin
            tick(1);
            n++;
        end
    endtask
    task automatic pulse();
        tick(4);
        per[0] <= 1'b1;
        tick(4);
        per[0] <= 1'b0;
        tick(4);
    endtask
    task automatic conclude();
        if (bad_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end
    initial begin
        rstn = 1'b0;
        lat = 10'd20 + 10'($random(seed) & 32'h1ff);
        tick(16);
        rstn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            tr = (k == 0) ? 0 : (k == 1) ? 127 : $random(seed) & 32'h7f;
            cd = $random(seed) & 32'hff;
            wr(A_TRIM1, 16'(tr));
            wr(A_CODE1, 16'(cd));
            tick(3);
            chk("peak code", 16'(pk1), 16'(cd * (189 + 2 * tr) / 315));
        end
        wr(A_CTRL, 16'h0005);
        dim[0] <= 1'b1;
        wt(1'b1, lr);
        lim[0] <= 1'b1;
        pulse();
        chk("flag early", 16'(flag[0]), 16'h0000);
        pulse();
        chk("flag", 16'(flag[0]), 16'h0001);
        lim[0] <= 1'b0;
        tick(20);
        chk("held off", 16'(on[0]), 16'h0000);
        rd(A_STATUS);
        chk("status", v & 16'h0003, 16'h0001);
        tick(3);
        chk("rearm", 16'({flag[0], on[0]}), 16'h0001);
        dim[0] <= 1'b0;
        wt(1'b0, lf);
        chk("delay", 16'(lr >= PHASE_DELAY_CYC + DEBOUNCE_CYC &&
            lr <= PHASE_DELAY_CYC + DEBOUNCE_CYC + 5), 16'h0001);
        chk("fall delay", 16'(lf), 16'(lr));
        tick(5000);
        for (int m = 0; m < 3; m++) begin
            rd(A_RES_BASE + 8'(m));
            chk("result", v, res(8'h31 * 8'(m + 1)));
        end
        rd(8'h24);
        chk("led1", v, res(8'hc4));
        rd(8'h23);
        chk("led1 on", v, 16'h0100);
        rd(8'h7f);
        chk("unmapped", v, 16'h0000);
        dim[0] <= 1'b1;
        wr(A_FORCED, 16'h0001);
        tick(15000);
        rd(8'h26);
        chk("led2 forced", v, res(8'hf5));
        rd(8'h23);
        chk("led1 on forced", v, res(8'hc4));
        conclude();
    end
endmodule // tb
